// >>> inc/scr_defs.svh
// scr_defs.svh: offsets, field positions and reset values of the
// system control registers. Definitions only; include by bare name.
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// io-space offsets
`define SCR_OFS_FLAGS     6'h00
`define SCR_OFS_STACK     6'h02
`define SCR_OFS_CLKMD     6'h03
`define SCR_OFS_IRQEN     6'h04
`define SCR_OFS_IRQPEND   6'h05
`define SCR_OFS_CNTMD     6'h06
`define SCR_OFS_BANDGAP   6'h0A
`define SCR_OFS_TRIM      6'h0B

// flag bits
`define SCR_FLG_OV        3
`define SCR_FLG_AC        2
`define SCR_FLG_C         1
`define SCR_FLG_Z         0
`define SCR_FLG_UPPER     4'hF

// clock mode bits
`define SCR_CLK_FAST_EN   4
`define SCR_CLK_TYPE      3
`define SCR_CLK_SLOW_EN   2
`define SCR_CLK_WDT_EN    1
`define SCR_CLK_RSTPIN    0

// irq bits, shared by enable and pending
`define SCR_IRQ_CNT       2
`define SCR_IRQ_PIN0      0

// reset values
`define SCR_RST_FLAGS     4'h0
`define SCR_RST_STACK     8'h00
`define SCR_RST_CLKMD     8'hF6
`define SCR_RST_CNTMD     8'h00
`define SCR_RST_TRIM      6'h00

// counter clock source codes
`define SCR_SRC_OFF       3'h0
`define SCR_SRC_SYS       3'h1
`define SCR_SRC_PIN4      3'h3
`define SCR_SRC_FAST      3'h4
`define SCR_SRC_SLOW      3'h6
`define SCR_SRC_PIN0      3'h7

// prescaler terminal counts, minus one
`define SCR_PRE_DIV4      6'h03
`define SCR_PRE_DIV16     6'h0F
`define SCR_PRE_DIV64     6'h3F

`endif

// >>> inc/scr_pkg.sv
// scr_pkg: types shared by the system control register block.
// Assumes scr_defs.svh is on the include path.
package scr_pkg;

    typedef enum logic [2:0] {
        SCR_OP_ADD,
        SCR_OP_SUB,
        SCR_OP_LOGIC,
        SCR_OP_RLC,
        SCR_OP_RRC
    } scr_alu_op_t;

    // one alu operation reported by the core
    typedef struct packed {
        logic        valid;
        scr_alu_op_t op;
        logic [7:0]  a;
        logic [7:0]  b;
        logic        cin;
        logic [7:0]  result;
    } scr_alu_t;

    // io-space access from the core
    typedef struct packed {
        logic [5:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } scr_io_t;

endpackage

// >>> src/scr_counter16.sv
// scr_counter16: sixteen-bit counter with prescaler and bit-tap event.
// Assumes count ticks are single-cycle pulses on clk_sys.
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_counter16
    import scr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // count control
    input  wire logic        tick,
    input  wire logic        use_pre,
    input  wire logic [1:0]  pre_sel,
    input  wire logic [2:0]  tap_sel,
    // core load path
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    // results
    output logic      [15:0] value,
    output logic             event_pulse
);
    logic [5:0] pre_r;
    logic [5:0] pre_top;
    logic       step;
    logic       tap_r;
    logic       tap_now;

    // prescaler only divides internal sources
    always_comb begin
        case (pre_sel)
            2'h1:    pre_top = `SCR_PRE_DIV4;
            2'h2:    pre_top = `SCR_PRE_DIV16;
            2'h3:    pre_top = `SCR_PRE_DIV64;
            default: pre_top = 6'h00;
        endcase
    end
    assign step = tick && (!use_pre || pre_r >= pre_top);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_r <= 6'h00;
        end else if (tick) begin
            pre_r <= step ? 6'h00 : pre_r + 6'h01;
        end
    end

    // the count itself; a core load wins over a step
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            value <= 16'h0000;
        end else if (load) begin
            value <= load_val;
        end else if (step) begin
            value <= value + 16'h0001;
        end
    end

    // event on any change of the tapped bit, 8 to 15
    assign tap_now = value[{1'b1, tap_sel}];
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tap_r       <= 1'b0;
            event_pulse <= 1'b0;
        end else begin
            tap_r       <= tap_now;
            event_pulse <= tap_now != tap_r;
        end
    end
endmodule // scr_counter16

// >>> src/scr_regs.sv
// scr_regs: system control and status registers of the core,
// reached in io space, with flag, stack, clock, irq and counter state.
// Assumes single-cycle io accesses from the core on clk_sys and
// asynchronous pins that are synchronised here.
//
// Notes on behaviour
// - flag register upper four bits always read as ones.
// - sign wrap flag set on signed overflow of add or subtract.
// - nibble carry flag: low nibble carry on add, borrow on subtract.
// - carry flag takes add carry, subtract borrow, rotate-through-carry.
// - zero flag follows whether an add, subtract or logic result is zero.
// - stack pointer reads current value; writes replace all eight bits.
// - clock mode bits 7:5 with type bit 3 choose system clock.
// - clock mode bit 4 enables fast oscillator, resets to one.
// - clock mode bit 2 enables slow oscillator; clearing stops watchdog.
// - clock mode bit 1 enables the watchdog, resets to one.
// - clock mode bit 0 picks port pin 5 or external reset pin.
// - enable bit 2 gates counter interrupt, resets to zero.
// - enable bit 0 gates pin 0 interrupt, resets to zero.
// - counter event sets pending bit 2 until software writes zero.
// - pin 0 qualifying edge sets pending bit 0; software clears.
// - counter mode bits 7:5 select count clock source.
// - counter mode bits 4:3 prescale internal sources by 1,4,16,64.
// - counter mode bits 2:0 pick tap bit 8..15 for the event.
// - band-gap register bit 0 powers down band-gap and low voltage reset.
// - trim register bits 5:0 set fast oscillator calibration.
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_regs
    import scr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // io-space access
    input  wire scr_io_t     io,
    output logic      [7:0]  io_rdata,
    // alu result report and stack updates from the core
    input  wire scr_alu_t    alu,
    input  wire logic        core_sp_we,
    input  wire logic [7:0]  core_sp_val,
    output logic      [7:0]  stack_ptr,
    // counter load path and value
    input  wire logic        cnt_load,
    input  wire logic [15:0] cnt_load_val,
    output logic      [15:0] cnt_value,
    // asynchronous inputs
    input  wire logic        port_a_pin0,
    input  wire logic        port_a_pin4,
    input  wire logic        fast_rc_osc_in,
    input  wire logic        slow_rc_osc_in,
    input  wire logic [1:0]  pin0_edge_sel,
    // clock and power control
    output logic      [2:0]  sysclk_sel,
    output logic             sysclk_type,
    output logic             sysclk_reserved,
    output logic             fast_rc_osc_en,
    output logic             slow_rc_osc_en,
    output logic             watchdog_en,
    output logic             external_reset_pin_en,
    output logic             bandgap_pd,
    output logic      [5:0]  fast_osc_trim,
    // interrupt to the core
    output logic             irq_to_core,
    output logic      [7:0]  irq_pending
);
    logic [3:0] flags_r;
    logic [3:0] flags_nxt;
    logic [7:0] sp_r;
    logic [7:0] clkmd_r;
    logic [7:0] irqen_r;
    logic [7:0] pend_r;
    logic [7:0] pend_nxt;
    logic [7:0] cntmd_r;
    logic       bgpd_r;
    logic [5:0] trim_r;
    logic [7:0] rdata_nxt;
    logic       wr_flags;
    logic       wr_stack;
    logic       wr_clkmd;
    logic       wr_irqen;
    logic       wr_pend;
    logic       wr_cntmd;
    logic       wr_bgap;
    logic       wr_trim;

    // io write decode
    assign wr_flags = io.wr && io.addr == `SCR_OFS_FLAGS;
    assign wr_stack = io.wr && io.addr == `SCR_OFS_STACK;
    assign wr_clkmd = io.wr && io.addr == `SCR_OFS_CLKMD;
    assign wr_irqen = io.wr && io.addr == `SCR_OFS_IRQEN;
    assign wr_pend  = io.wr && io.addr == `SCR_OFS_IRQPEND;
    assign wr_cntmd = io.wr && io.addr == `SCR_OFS_CNTMD;
    assign wr_bgap  = io.wr && io.addr == `SCR_OFS_BANDGAP;
    assign wr_trim  = io.wr && io.addr == `SCR_OFS_TRIM;

    // pin synchronisers: the first stage feeds only the second
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic [3:0] async_in;
    logic [3:0] rise;
    logic [3:0] fall;
    assign async_in = {slow_rc_osc_in, fast_rc_osc_in,
                       port_a_pin4, port_a_pin0};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            sync3_r <= 4'h0;
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // edge detectors, one per synchronised input
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_edge
            assign rise[gi] = sync2_r[gi] && !sync3_r[gi];
            assign fall[gi] = !sync2_r[gi] && sync3_r[gi];
        end
    endgenerate

    // edge select also synchronised; it comes from another register
    logic [1:0] esel1_r;
    logic [1:0] esel2_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            esel1_r <= 2'h0;
            esel2_r <= 2'h0;
        end else begin
            esel1_r <= pin0_edge_sel;
            esel2_r <= esel1_r;
        end
    end

    // alu flag computation
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic       bin;
    always_comb begin
        flags_nxt = flags_r;
        bin       = alu.cin;
        sum9      = 9'h000;
        nib5      = 5'h00;
        case (alu.op)
            SCR_OP_ADD: begin
                sum9 = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, alu.cin};
                nib5 = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]}
                     + {4'h0, alu.cin};
                flags_nxt[`SCR_FLG_C]  = sum9[8];
                flags_nxt[`SCR_FLG_AC] = nib5[4];
                flags_nxt[`SCR_FLG_OV] = (alu.a[7] == alu.b[7])
                    && (sum9[7] != alu.a[7]);
                flags_nxt[`SCR_FLG_Z]  = sum9[7:0] == 8'h00;
            end
            SCR_OP_SUB: begin
                sum9 = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, bin};
                nib5 = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]}
                     - {4'h0, bin};
                flags_nxt[`SCR_FLG_C]  = sum9[8]; // borrow
                flags_nxt[`SCR_FLG_AC] = nib5[4];
                flags_nxt[`SCR_FLG_OV] = (alu.a[7] != alu.b[7])
                    && (sum9[7] != alu.a[7]);
                flags_nxt[`SCR_FLG_Z]  = sum9[7:0] == 8'h00;
            end
            SCR_OP_LOGIC: begin
                flags_nxt[`SCR_FLG_Z] = alu.result == 8'h00;
            end
            SCR_OP_RLC: begin
                flags_nxt[`SCR_FLG_C] = alu.a[7];
            end
            SCR_OP_RRC: begin
                flags_nxt[`SCR_FLG_C] = alu.a[0];
            end
            default: begin
                flags_nxt = flags_r;
            end
        endcase
    end

    // flag register; an explicit io write beats an alu update
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_r <= `SCR_RST_FLAGS;
        end else if (wr_flags) begin
            flags_r <= io.wdata[3:0];
        end else if (alu.valid) begin
            flags_r <= flags_nxt;
        end
    end

    // stack pointer; bit 0 is stored as written, software keeps it 0
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sp_r <= `SCR_RST_STACK;
        end else if (wr_stack) begin
            sp_r <= io.wdata;
        end else if (core_sp_we) begin
            sp_r <= core_sp_val;
        end
    end
    assign stack_ptr = sp_r;

    // clock mode register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clkmd_r <= `SCR_RST_CLKMD;
        end else if (wr_clkmd) begin
            clkmd_r <= io.wdata;
        end
    end

    // clock outputs and reserved-code indication
    assign sysclk_sel            = clkmd_r[7:5];
    assign sysclk_type           = clkmd_r[`SCR_CLK_TYPE];
    assign fast_rc_osc_en        = clkmd_r[`SCR_CLK_FAST_EN];
    assign slow_rc_osc_en        = clkmd_r[`SCR_CLK_SLOW_EN];
    // watchdog counts the slow oscillator, so it stops with it
    assign watchdog_en           = clkmd_r[`SCR_CLK_WDT_EN]
                                 && clkmd_r[`SCR_CLK_SLOW_EN];
    assign external_reset_pin_en = clkmd_r[`SCR_CLK_RSTPIN];

    always_comb begin
        if (clkmd_r[`SCR_CLK_TYPE]) begin
            case (clkmd_r[7:5])
                3'h0, 3'h1, 3'h3, 3'h4: sysclk_reserved = 1'b0;
                default:                sysclk_reserved = 1'b1;
            endcase
        end else begin
            case (clkmd_r[7:5])
                3'h0, 3'h1, 3'h6, 3'h7: sysclk_reserved = 1'b0;
                default:                sysclk_reserved = 1'b1;
            endcase
        end
    end

    // interrupt enable, only the two implemented bits are stored
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqen_r <= 8'h00;
        end else if (wr_irqen) begin
            irqen_r <= io.wdata & 8'h05;
        end
    end

    // counter mode register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cntmd_r <= `SCR_RST_CNTMD;
        end else if (wr_cntmd) begin
            cntmd_r <= io.wdata;
        end
    end

    // count tick per source; reserved codes count nothing
    logic cnt_tick;
    logic cnt_internal;
    always_comb begin
        cnt_internal = 1'b1;
        case (cntmd_r[7:5])
            `SCR_SRC_SYS:  cnt_tick = 1'b1;
            `SCR_SRC_PIN4: begin
                cnt_tick     = fall[1];
                cnt_internal = 1'b0;
            end
            `SCR_SRC_FAST: cnt_tick = rise[2];
            `SCR_SRC_SLOW: cnt_tick = rise[3];
            `SCR_SRC_PIN0: begin
                cnt_tick     = fall[0];
                cnt_internal = 1'b0;
            end
            default:       cnt_tick = 1'b0;
        endcase
    end

    // the counter; fast oscillator ticks are only as fine as clk_sys
    logic cnt_event;
    scr_counter16 u_counter (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .tick        (cnt_tick),
        .use_pre     (cnt_internal),
        .pre_sel     (cntmd_r[4:3]),
        .tap_sel     (cntmd_r[2:0]),
        .load        (cnt_load),
        .load_val    (cnt_load_val),
        .value       (cnt_value),
        .event_pulse (cnt_event)
    );

    // pin 0 edge qualification: 00 both, 01 rising, 10 falling
    logic pin0_event;
    always_comb begin
        case (esel2_r)
            2'h0:    pin0_event = rise[0] || fall[0];
            2'h1:    pin0_event = rise[0];
            2'h2:    pin0_event = fall[0];
            default: pin0_event = 1'b0;
        endcase
    end

    // pending bits: hardware set wins over a software clear
    always_comb begin
        pend_nxt = wr_pend ? (io.wdata & 8'h05) : pend_r;
        pend_nxt[`SCR_IRQ_CNT]  = pend_nxt[`SCR_IRQ_CNT]
                                || cnt_event;
        pend_nxt[`SCR_IRQ_PIN0] = pend_nxt[`SCR_IRQ_PIN0]
                                || pin0_event;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_r <= 8'h00;
        end else begin
            pend_r <= pend_nxt;
        end
    end
    assign irq_pending = pend_r;

    // enables gate only the request to the core, not the pending bits
    assign irq_to_core = |(pend_r & irqen_r);

    // write-only power and trim registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bgpd_r <= 1'b0;
        end else if (wr_bgap) begin
            bgpd_r <= io.wdata[0];
        end
    end
    assign bandgap_pd = bgpd_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trim_r <= `SCR_RST_TRIM;
        end else if (wr_trim) begin
            trim_r <= io.wdata[5:0];
        end
    end
    assign fast_osc_trim = trim_r;

    // read mux; write-only and unmapped addresses read zero
    always_comb begin
        case (io.addr)
            `SCR_OFS_FLAGS:   rdata_nxt = {`SCR_FLG_UPPER, flags_r};
            `SCR_OFS_STACK:   rdata_nxt = sp_r;
            `SCR_OFS_CLKMD:   rdata_nxt = clkmd_r;
            `SCR_OFS_IRQEN:   rdata_nxt = irqen_r;
            `SCR_OFS_IRQPEND: rdata_nxt = pend_r;
            `SCR_OFS_CNTMD:   rdata_nxt = cntmd_r;
            default:          rdata_nxt = 8'h00;
        endcase
    end

    // read data registered; held between reads
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_rdata <= 8'h00;
        end else if (io.rd) begin
            io_rdata <= rdata_nxt;
        end
    end
endmodule // scr_regs

// >>> tb/scr_regs_sva.sv
// scr_regs_sva: port-level checks of the system control registers.
// Assumes it is bound to scr_regs and sees only that module's ports.
`timescale 1ns/1ps
module scr_regs_sva
    import scr_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // core side
    input wire scr_io_t     io,
    input wire scr_alu_t    alu,
    input wire logic [7:0]  io_rdata,
    input wire logic [7:0]  stack_ptr,
    // clock, power and irq outputs
    input wire logic [2:0]  sysclk_sel,
    input wire logic        sysclk_type,
    input wire logic        fast_rc_osc_en,
    input wire logic        watchdog_en,
    input wire logic        external_reset_pin_en,
    input wire logic        bandgap_pd,
    input wire logic [5:0]  fast_osc_trim,
    input wire logic        irq_to_core,
    input wire logic [7:0]  irq_pending
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // decoded write strobe, shared by the clock mode checks
    wire logic wr_clk = io.wr && io.addr == 6'h03;

    chk_flag_upper: assert property (
        io.rd && io.addr == 6'h00 |=> io_rdata[7:4] == 4'hF)
        else $error("flag upper nibble not ones");
    chk_wo_zero: assert property (
        io.rd && io.addr inside {6'h0A, 6'h0B} |=> io_rdata == 8'h00)
        else $error("write-only register read not zero");
    chk_stack_wr: assert property (
        io.wr && io.addr == 6'h02 |=> stack_ptr == $past(io.wdata))
        else $error("stack pointer write lost");
    chk_clk_fields: assert property (
        wr_clk |=> {sysclk_sel, fast_rc_osc_en, sysclk_type,
        external_reset_pin_en} == {$past(io.wdata[7:3]), $past(io.wdata[0])})
        else $error("clock mode fields wrong");
    chk_wdt_gate: assert property (
        wr_clk |=> watchdog_en == ($past(io.wdata[2]) && $past(io.wdata[1])))
        else $error("watchdog enable wrong");
    chk_bandgap_wr: assert property (
        io.wr && io.addr == 6'h0A |=> bandgap_pd == $past(io.wdata[0]))
        else $error("band-gap power-down wrong");
    chk_trim_wr: assert property (
        io.wr && io.addr == 6'h0B |=> fast_osc_trim == $past(io.wdata[5:0]))
        else $error("trim code wrong");
    chk_pend_sticky: assert property (
        (irq_pending[2] || irq_pending[0]) && !(io.wr && io.addr == 6'h05)
        |=> (~irq_pending & $past(irq_pending) & 8'h05) == 8'h00)
        else $error("pending bit dropped without software");
    chk_irq_idle: assert property (
        irq_pending == 8'h00 |-> !irq_to_core)
        else $error("interrupt without pending request");
    chk_zero_flag: assert property (
        alu.valid && alu.op inside {SCR_OP_ADD, SCR_OP_SUB, SCR_OP_LOGIC}
        && !io.wr ##1 io.rd && io.addr == 6'h00 && !alu.valid
        |=> io_rdata[0] == ($past(alu.result, 2) == 8'h00))
        else $error("zero flag does not follow result");
endmodule // scr_regs_sva

bind scr_regs scr_regs_sva u_scr_regs_sva (.clk_sys, .rst, .io, .alu,
    .io_rdata, .stack_ptr, .sysclk_sel, .sysclk_type, .fast_rc_osc_en,
    .watchdog_en, .external_reset_pin_en, .bandgap_pd, .fast_osc_trim,
    .irq_to_core, .irq_pending);

// >>> tb/tb_top.sv
// tb_top: self-checking bench for the system control registers.
// Assumes scr_pkg is compiled first; inputs move 2 ns after each edge.
`timescale 1ns/1ps
module tb_top;
    import scr_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, core_sp_we = 0, cnt_load = 0;
    logic [7:0] core_sp_val = 0, io_rdata, stack_ptr, irq_pending;
    logic [15:0] cnt_load_val = 0, cnt_value, ent, v0;
    logic [3:0] tog = 0;
    logic [1:0] pin0_edge_sel = 0;
    logic [2:0] sysclk_sel, srcs[4] = '{3'h3, 3'h4, 3'h6, 3'h7};
    logic sysclk_type, sysclk_reserved, fast_rc_osc_en, slow_rc_osc_en;
    logic watchdog_en, external_reset_pin_en, bandgap_pd, irq_to_core;
    logic rd_seen = 0;
    logic [5:0] fast_osc_trim;
    scr_io_t io = '0;
    scr_alu_t alu = '0;
    int err_count = 0, cmp_count = 0, seed = 31146, i, j;

    scr_regs dut (.clk_sys, .rst, .io, .io_rdata, .alu, .core_sp_we,
        .core_sp_val, .stack_ptr, .cnt_load, .cnt_load_val, .cnt_value,
        .port_a_pin0(tog[3]), .port_a_pin4(tog[0]),
        .fast_rc_osc_in(tog[1]), .slow_rc_osc_in(tog[2]), .pin0_edge_sel,
        .sysclk_sel, .sysclk_type, .sysclk_reserved, .fast_rc_osc_en,
        .slow_rc_osc_en, .watchdog_en, .external_reset_pin_en,
        .bandgap_pd, .fast_osc_trim, .irq_to_core, .irq_pending);

    always #10 clk_sys = ~clk_sys;

    task automatic check(string what, logic [15:0] e, logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", what, e, s);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    logic [15:0] exp_q[$];
    // read data lands on the edge after the read; compare oldest note
    always @(posedge clk_sys) rd_seen <= io.rd && !rst;
    always @(negedge clk_sys) begin
        if (rd_seen && exp_q.size() > 0) begin
            ent = exp_q.pop_front();
            check("io_rdata", ent[7:0] & ent[15:8], io_rdata & ent[15:8]);
        end
    end

    // bus tasks leave strobes up; step releases them before waiting
    task automatic step(int n);
        io.rd = 0; io.wr = 0; alu.valid = 0; cnt_load = 0; core_sp_we = 0;
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic io_wr(logic [5:0] a, logic [7:0] d);
        io = '{a, 1'b0, 1'b1, d};
        alu.valid = 0;
        @(posedge clk_sys); #2;
    endtask
    task automatic io_rd(logic [5:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
        io = '{a, 1'b1, 1'b0, 8'h00};
        alu.valid = 0;
        exp_q.push_back({m, e});
        @(posedge clk_sys); #2;
    endtask
    task automatic alu_op(scr_alu_op_t op, logic [7:0] a, b, r);
        alu = '{1'b1, op, a, b, 1'b0, r};
        io.rd = 0; io.wr = 0;
        @(posedge clk_sys); #2;
    endtask
    // waits boundedly for a pending bit; a timeout ends the run
    task automatic wait_pend(int b);
        for (i = 0; i < 16 && irq_pending[b] !== 1'b1; i++) step(1);
        if (i == 16) begin
            err_count++;
            $display("mismatch irq_pending wait exp 1 got 0");
            report_and_stop();
        end
    endtask
    // expected result and flags {ov, ac, c, z} of add or subtract
    function automatic logic [11:0] alu_exp(logic sub, logic [7:0] a, b);
        logic [8:0] s;
        logic [4:0] n;
        s = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        n = sub ? {1'b0, a[3:0]} - b[3:0] : {1'b0, a[3:0]} + b[3:0];
        return {s[7:0], (a[7] ^ sub) == b[7] && s[7] != a[7], n[4], s[8],
            s[7:0] == 8'h00};
    endfunction

    logic [5:0] ra[9] = '{6'h00, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0A,
        6'h0B, 6'h3F};
    logic [7:0] rv[9] = '{8'hF0, 8'h00, 8'hF6, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00};
    logic [16:0] tv[4] = '{{1'h0, 8'hFF, 8'h01}, {1'h0, 8'h7F, 8'h01},
        {1'h1, 8'h00, 8'h01}, {1'h1, 8'h80, 8'h01}};
    logic [16:0] t;
    logic [11:0] x;

    initial begin
        repeat (10) @(posedge clk_sys);
        #2 rst = 0;
        for (j = 0; j < 9; j++) io_rd(ra[j], rv[j]);
        step(1);
        check("clk_out", {sysclk_sel, sysclk_type, sysclk_reserved,
            fast_rc_osc_en, slow_rc_osc_en, watchdog_en,
            external_reset_pin_en}, 16'h01CE);
        $display("test reset done");
        io_wr(6'h00, 8'h0F); io_rd(6'h00, 8'hFF);
        for (j = 0; j < 16; j++) begin
            t = j < 4 ? tv[j] : 17'($random(seed));
            x = alu_exp(t[16], t[15:8], t[7:0]);
            alu_op(t[16] ? SCR_OP_SUB : SCR_OP_ADD, t[15:8], t[7:0], x[11:4]);
            io_rd(6'h00, {4'hF, x[3:0]});
        end
        alu_op(SCR_OP_LOGIC, 8'h00, 8'h00, 8'h00); io_rd(6'h00, 1, 1);
        alu_op(SCR_OP_LOGIC, 8'h0F, 8'h00, 8'h5A); io_rd(6'h00, 0, 1);
        alu_op(SCR_OP_RLC, 8'h80, 8'h00, 8'h00); io_rd(6'h00, 2, 2);
        alu_op(SCR_OP_RRC, 8'hFE, 8'h00, 8'h7F); io_rd(6'h00, 0, 2);
        step(1);
        $display("test flags done");
        io_wr(6'h02, 8'h7E); io_rd(6'h02, 8'h7E);
        core_sp_we = 1; core_sp_val = 8'h40;
        io_wr(6'h02, 8'h3C); io_rd(6'h02, 8'h3C); step(1);
        io_rd(6'h02, 8'h40); step(1);
        check("stack_ptr", 16'h0040, {8'h00, stack_ptr});
        $display("test stack done");
        for (j = 0; j < 16; j++) begin
            io_wr(6'h03, {j[3:1], 1'b1, j[0], j[0], 1'b1, j[0]});
            check("clk_out", {sysclk_sel, sysclk_type, sysclk_reserved,
                fast_rc_osc_en, slow_rc_osc_en, watchdog_en,
                external_reset_pin_en}, {j[3:0], !(j[0] ?
                j[3:1] inside {0, 1, 3, 4} : j[3:1] inside {0, 1, 6, 7}),
                1'b1, j[0], j[0], j[0]});
        end
        io_wr(6'h03, 8'hF6); io_rd(6'h03, 8'hF6);
        io_wr(6'h04, 8'hFF); io_rd(6'h04, 8'h05);
        io_wr(6'h0A, 8'h01); io_wr(6'h0B, 8'hFF);
        io_rd(6'h0A, 8'h00); io_rd(6'h0B, 8'h00); step(1);
        check("pd_trim", 16'h007F, {bandgap_pd, fast_osc_trim});
        io_wr(6'h0A, 8'h00);
        $display("test control done");
        for (j = 0; j < 5; j++) begin
            io_wr(6'h06, j < 4 ? {3'h1, j[1:0], 3'h0} : 8'h00);
            step(2); v0 = cnt_value; step(64);
            check("cnt_step", j < 4 ? 16'd64 >> (2 * j) : 16'h0,
                cnt_value - v0);
        end
        for (j = 0; j < 4; j++) begin
            io_wr(6'h06, {srcs[j], 5'h00}); step(4); v0 = cnt_value;
            repeat (4) begin
                tog[j] = 1; step(3); tog[j] = 0; step(3);
            end
            step(6);
            check("cnt_edges", 16'h0004, cnt_value - v0);
        end
        for (j = 0; j < 8; j++) begin
            io_wr(6'h06, {3'h1, 2'h0, j[2:0]}); step(2); io_wr(6'h05, 8'h00);
            cnt_load = 1; cnt_load_val = (16'h0100 << j) - 16'h0003;
            @(posedge clk_sys); #2;
            wait_pend(2);
            check("irq_to_core", 16'h1, irq_to_core);
        end
        io_wr(6'h06, 8'h00); step(20);
        io_rd(6'h05, 8'h04, 8'h04); io_wr(6'h05, 8'h00);
        io_rd(6'h05, 8'h00); io_wr(6'h04, 8'h00); step(1);
        $display("test counter done");
        for (j = 0; j < 8; j++) begin
            pin0_edge_sel = j[2:1]; step(4);
            io_wr(6'h05, 8'h00); step(1);
            tog[3] = ~tog[3]; step(8);
            io_rd(6'h05, {7'h00, j[2:1] == 0 || j[2:1] == 1 && tog[3]
                || j[2:1] == 2 && !tog[3]}); step(1);
            check("irq_to_core", 16'h0, irq_to_core);
        end
        $display("test pin0 done");
        report_and_stop();
    end
endmodule // tb_top
